// ==== src/pmc_defines.svh ====
// Constants of the power mode controller: mode codes, reset causes, timing.
// Assumes a single 100 MHz clock; included by bare name.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_NUM_GPIO        30
`define PMC_TGT_STANDBY     1'b0
`define PMC_TGT_SHUTDOWN    1'b1
`define PMC_CAUSE_POR       2'h0
`define PMC_CAUSE_PIN       2'h1
`define PMC_CAUSE_WAKE      2'h2
`define PMC_RET_NONE        2'h0
`define PMC_RET_PARTIAL     2'h1
`define PMC_RET_FULL        2'h2
`define PMC_SETTLE_NS       100
`define PMC_CLK_NS          10
`define PMC_SETTLE_CYC      ((`PMC_SETTLE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`endif

// ==== src/pmc_pkg.sv ====
// Types of the power mode controller.
// Assumes the defines header is compiled alongside.
package pmc_pkg;
	typedef enum logic [5:0]
	{
		ST_ACTIVE   = 6'h01,
		ST_IDLE     = 6'h02,
		ST_STANDBY  = 6'h04,
		ST_SHUTDOWN = 6'h08,
		ST_HELD     = 6'h10,
		ST_WAKEUP   = 6'h20
	} mode_t;
endpackage

// ==== src/pmc_sync_if.sv ====
// Carries synchronised wake inputs from the synchroniser to the controller.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface pmc_sync_if;
	logic       reset_pin_n;
	logic [29:0] pins;
	logic       pin_change;
	modport src (output reset_pin_n, output pins, output pin_change);
	modport dst (input reset_pin_n, input pins, input pin_change);
endinterface
`default_nettype wire

// ==== src/pmc_pin_sync.sv ====
// Three-stage synchroniser for the reset pin and GPIO pins.
// A level counts once stages two and three agree; first stage is read by stage two only.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module pmc_pin_sync
(
	// Clock and reset
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst_n,
	// Raw pins
	input  wire logic                     i_reset_pin_n,
	input  wire logic [`PMC_NUM_GPIO-1:0] i_gpio_in,
	// Synchronised side
	pmc_sync_if.src                       sync
);
	logic [`PMC_NUM_GPIO:0] s1_q;
	logic [`PMC_NUM_GPIO:0] s2_q;
	logic [`PMC_NUM_GPIO:0] s3_q;
	logic [`PMC_NUM_GPIO:0] stable_q;

	// Shift chain; reset pin idles high
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			s1_q <= {1'b1, {`PMC_NUM_GPIO{1'b0}}};
			s2_q <= {1'b1, {`PMC_NUM_GPIO{1'b0}}};
			s3_q <= {1'b1, {`PMC_NUM_GPIO{1'b0}}};
		end
		else
		begin
			s1_q <= {i_reset_pin_n, i_gpio_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a bit only where stages two and three agree
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			stable_q <= {1'b1, {`PMC_NUM_GPIO{1'b0}}};
		else
			stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
	end

	assign sync.reset_pin_n = stable_q[`PMC_NUM_GPIO];
	assign sync.pins        = stable_q[`PMC_NUM_GPIO-1:0];
	assign sync.pin_change  = 1'b0;
endmodule
`default_nettype wire

// ==== src/power_mode_controller.sv ====
// Power mode controller: mode machine, clock and power enables, I/O latch, reset cause.
// Assumes wake events from the same clock, pins raw from outside.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module power_mode_controller
(
	// Clock and reset
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst_n,
	// CPU requests
	input  wire logic                     i_idle_req,
	input  wire logic                     i_deep_req,
	input  wire logic                     i_deep_target,
	// Same-clock wake events and oscillator crystal selects
	input  wire logic                     i_irq,
	input  wire logic                     i_rtc_event,
	input  wire logic                     i_sensor_event,
	input  wire logic                     i_ext_wake,
	input  wire logic                     i_hs_use_crystal,
	input  wire logic                     i_ls_use_crystal,
	// Pins
	input  wire logic                     i_reset_pin_n,
	input  wire logic [`PMC_NUM_GPIO-1:0] i_gpio_in,
	input  wire logic [`PMC_NUM_GPIO-1:0] i_gpio_out,
	input  wire logic [`PMC_NUM_GPIO-1:0] i_shutdown_wake_en,
	// Mode and enables
	output logic [5:0]                    o_mode,
	output logic                          o_cpu_clk_en,
	output logic                          o_mem_clk_en,
	output logic                          o_periph_clk_en,
	output logic                          o_always_on_domain_pwr,
	output logic                          o_sensor_ctrl_pwr,
	output logic                          o_high_speed_crystal_osc_en,
	output logic                          o_high_speed_rc_osc_en,
	output logic                          o_medium_speed_rc_osc_en,
	output logic                          o_low_speed_crystal_osc_en,
	output logic                          o_low_speed_rc_osc_en,
	output logic                          o_brownout_detector_en,
	output logic                          o_watchdog_timer_run,
	output logic [1:0]                    o_reg_retention,
	output logic                          o_sram_retain,
	output logic                          o_cpu_resume,
	output logic                          o_sys_reset,
	// I/O latch and reset cause
	output logic [`PMC_NUM_GPIO-1:0]      o_gpio_pad,
	output logic                          o_io_latched,
	output logic [1:0]                    o_reset_cause
);
	pmc_sync_if sync ();
	pmc_pkg::mode_t                mode_q;
	pmc_pkg::mode_t                mode_d;
	logic [`PMC_NUM_GPIO-1:0]      latch_q;
	logic [`PMC_NUM_GPIO-1:0]      wake_ref_q;
	logic [1:0]                    cause_q;
	logic [7:0]                    settle_q;
	logic                          resume_q;
	logic                          from_shutdown_q;
	logic                          pin_wake;

	// True where the CPU side still runs; latch, pad and clock decode must agree on it
	function automatic logic cpu_side_on(input pmc_pkg::mode_t m);
		return (m == pmc_pkg::ST_ACTIVE) || (m == pmc_pkg::ST_IDLE);
	endfunction

	pmc_pin_sync u_sync
	(
		.i_mclk        (i_mclk),
		.i_rst_n       (i_rst_n),
		.i_reset_pin_n (i_reset_pin_n),
		.i_gpio_in     (i_gpio_in),
		.sync          (sync)
	);

	// Any enabled wake pin that differs from its value at entry
	assign pin_wake = |((sync.pins ^ wake_ref_q) & i_shutdown_wake_en);

	// Next mode; the reset pin overrides every mode
	always_comb
	begin
		mode_d = mode_q;
		case (mode_q)
			pmc_pkg::ST_ACTIVE:
			begin
				// Leave active only on an explicit request
				if (i_deep_req)
					mode_d = (i_deep_target == `PMC_TGT_SHUTDOWN) ?
						pmc_pkg::ST_SHUTDOWN : pmc_pkg::ST_STANDBY;
				else if (i_idle_req)
					mode_d = pmc_pkg::ST_IDLE;
			end
			pmc_pkg::ST_IDLE:
				if (i_irq)
					mode_d = pmc_pkg::ST_ACTIVE;
			pmc_pkg::ST_STANDBY:
				if (i_ext_wake || i_rtc_event || i_sensor_event)
					mode_d = pmc_pkg::ST_ACTIVE;
			pmc_pkg::ST_SHUTDOWN:
				if (pin_wake)
					mode_d = pmc_pkg::ST_WAKEUP;
			pmc_pkg::ST_HELD:
				if (sync.reset_pin_n)
					mode_d = pmc_pkg::ST_WAKEUP;
			pmc_pkg::ST_WAKEUP:
				if (settle_q == 8'h00)
					mode_d = pmc_pkg::ST_ACTIVE;
			default:
				mode_d = pmc_pkg::ST_WAKEUP;
		endcase
		if (!sync.reset_pin_n)
			mode_d = pmc_pkg::ST_HELD;
	end

	// Mode register
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			mode_q <= pmc_pkg::ST_WAKEUP;
		else
			mode_q <= mode_d;
	end

	// Boot settle counter, reloaded whenever the wake-up state is entered
	// Fixed length: the oscillators get the same start-up time on every boot path
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			settle_q <= 8'(`PMC_SETTLE_CYC);
		else if (mode_q != pmc_pkg::ST_WAKEUP)
			settle_q <= 8'(`PMC_SETTLE_CYC);
		else if (settle_q != 8'h00)
			settle_q <= settle_q - 8'h01;
	end

	// Reset cause: pin cause written while held, wake cause written in the wake-up state after a shutdown
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			cause_q         <= `PMC_CAUSE_POR;
			from_shutdown_q <= 1'b0;
		end
		else
		begin
			if (mode_d == pmc_pkg::ST_HELD)
				from_shutdown_q <= 1'b0;
			else if (mode_q == pmc_pkg::ST_SHUTDOWN && mode_d == pmc_pkg::ST_WAKEUP)
				from_shutdown_q <= 1'b1;
			if (mode_q == pmc_pkg::ST_HELD)
				cause_q <= `PMC_CAUSE_PIN;
			else if (mode_q == pmc_pkg::ST_WAKEUP && from_shutdown_q)
				cause_q <= `PMC_CAUSE_WAKE;
		end
	end

	// Resume flag: a standby exit continues the program, reset-type exits restart it
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			resume_q <= 1'b0;
		else
			resume_q <= (mode_q == pmc_pkg::ST_STANDBY) && (mode_d == pmc_pkg::ST_ACTIVE);
	end

	// I/O latch: tracks the core outputs while the CPU side runs, frozen from entry on;
	// idle tracks too, so a reset-pin hold taken from idle freezes the value shown there
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			latch_q    <= {`PMC_NUM_GPIO{1'b0}};
			wake_ref_q <= {`PMC_NUM_GPIO{1'b0}};
		end
		else if (cpu_side_on(mode_q))
		begin
			latch_q    <= i_gpio_out;
			wake_ref_q <= sync.pins;
		end
	end

	// Pad value: live in active and idle, frozen otherwise; latch survives reset paths
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			o_gpio_pad <= {`PMC_NUM_GPIO{1'b0}};
		else if (cpu_side_on(mode_q))
			o_gpio_pad <= i_gpio_out;
		else
			o_gpio_pad <= latch_q;
	end

	// Per-mode clock, power and retention decode
	// Decoded from the registered mode and the two crystal selects, so no enable can glitch on a request
	always_comb
	begin
		o_cpu_clk_en           = (mode_q == pmc_pkg::ST_ACTIVE);
		o_mem_clk_en           = (mode_q == pmc_pkg::ST_ACTIVE);
		o_periph_clk_en        = cpu_side_on(mode_q);
		o_always_on_domain_pwr = (mode_q != pmc_pkg::ST_SHUTDOWN) &&
			(mode_q != pmc_pkg::ST_HELD);
		o_sensor_ctrl_pwr      = o_always_on_domain_pwr;
		o_high_speed_crystal_osc_en = o_periph_clk_en && i_hs_use_crystal;
		o_high_speed_rc_osc_en      = o_periph_clk_en && !i_hs_use_crystal;
		o_medium_speed_rc_osc_en    = o_always_on_domain_pwr;
		o_low_speed_crystal_osc_en  = o_always_on_domain_pwr && i_ls_use_crystal;
		o_low_speed_rc_osc_en       = o_always_on_domain_pwr && !i_ls_use_crystal;
		o_brownout_detector_en = o_always_on_domain_pwr;
		o_watchdog_timer_run   = o_periph_clk_en;
		o_io_latched           = !o_periph_clk_en && (mode_q != pmc_pkg::ST_WAKEUP);
		o_sram_retain          = o_always_on_domain_pwr;
		if (o_periph_clk_en)
			o_reg_retention = `PMC_RET_FULL;
		else if (mode_q == pmc_pkg::ST_STANDBY)
			o_reg_retention = `PMC_RET_PARTIAL;
		else
			o_reg_retention = `PMC_RET_NONE;
		o_sys_reset = (mode_q == pmc_pkg::ST_HELD) || (mode_q == pmc_pkg::ST_WAKEUP) ||
			(mode_q == pmc_pkg::ST_SHUTDOWN);
	end

	assign o_mode        = mode_q;
	assign o_cpu_resume  = resume_q;
	assign o_reset_cause = cause_q;
endmodule
`default_nettype wire

// ==== tb/pmc_checker.sv ====
// Concurrent checks on the power mode controller ports.
// Assumes one clock and the one-hot mode codes of the package.
`timescale 1ns/1ps
`default_nettype none
module pmc_checker
(
	// Clock, reset and inputs
	input wire logic        i_mclk,
	input wire logic        i_rst_n,
	input wire logic        i_irq,
	input wire logic        i_reset_pin_n,
	input wire logic        i_idle_req,
	input wire logic        i_deep_req,
	input wire logic [29:0] i_gpio_in,
	input wire logic [29:0] i_shutdown_wake_en,
	// Observed outputs
	input wire logic [5:0]  o_mode,
	input wire logic        o_cpu_clk_en,
	input wire logic        o_periph_clk_en,
	input wire logic        o_always_on_domain_pwr,
	input wire logic        o_high_speed_rc_osc_en,
	input wire logic        o_medium_speed_rc_osc_en,
	input wire logic        o_low_speed_rc_osc_en,
	input wire logic [1:0]  o_reg_retention,
	input wire logic        o_cpu_resume,
	input wire logic [29:0] o_gpio_pad,
	input wire logic        o_io_latched
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	// Mode codes: 01 active, 02 idle, 04 standby, 08 shutdown, 10 held
	a_idle_gated: assert property (o_mode == 6'h02 |-> !o_cpu_clk_en && o_periph_clk_en)
		else $error("idle clock gating wrong");
	a_idle_irq_wake: assert property (
		o_mode == 6'h02 && i_irq && i_reset_pin_n |=> o_mode == 6'h01)
		else $error("interrupt did not end idle");
	a_standby_state: assert property (
		o_mode == 6'h04 |-> o_always_on_domain_pwr && !o_periph_clk_en
		&& !o_high_speed_rc_osc_en && o_medium_speed_rc_osc_en && o_io_latched
		&& o_reg_retention == 2'h1)
		else $error("standby enables wrong");
	a_shutdown_off: assert property (
		o_mode == 6'h08 |-> !o_always_on_domain_pwr && !o_medium_speed_rc_osc_en
		&& !o_low_speed_rc_osc_en && o_io_latched && o_reg_retention == 2'h0)
		else $error("shutdown left something powered");
	// Latched pads may only move on the edge that latches them
	a_pad_frozen: assert property (
		o_io_latched && $past(o_io_latched) |-> $stable(o_gpio_pad))
		else $error("latched pads moved");
	a_resume_pulse: assert property (
		o_mode == 6'h01 && $past(o_mode) == 6'h04 |-> ##[0:1] o_cpu_resume)
		else $error("no resume after standby");
	a_held_forced: assert property (
		(!i_reset_pin_n) [*6] |-> o_mode == 6'h10 && !o_cpu_clk_en && !o_medium_speed_rc_osc_en)
		else $error("reset pin hold not honoured");
	a_pin_wake: assert property (
		o_mode == 6'h08 && i_reset_pin_n && $changed(i_gpio_in & i_shutdown_wake_en)
		|-> ##[1:6] o_mode == 6'h20)
		else $error("wake pin ignored in shutdown");
	a_stay_active: assert property (
		o_mode == 6'h01 && !i_idle_req && !i_deep_req && i_reset_pin_n |=> o_mode == 6'h01)
		else $error("left active without request");
endmodule
`default_nettype wire

// ==== tb/pmc_cpu_partner.sv ====
// Model of the CPU and the wake sources around the controller.
// Changes every output just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module pmc_cpu_partner
(
	// Clock
	input  wire logic       i_mclk,
	// Requests, wake pulses (irq, rtc, sensor, external) and reset pin
	output var  logic       o_idle_req,
	output var  logic       o_deep_req,
	output var  logic       o_deep_target,
	output var  logic [3:0] o_wake,
	output var  logic       o_reset_pin_n
);
	// Quiet outputs until the bench asks for something
	initial
	begin
		{o_idle_req, o_deep_req, o_deep_target, o_wake, o_reset_pin_n} = 8'h01;
	end
	// Kind 0 idle, 1 standby, 2 shutdown; the target settles a cycle before the request
	task automatic request(input int kind);
		@(negedge i_mclk);
		o_deep_target = (kind == 2);
		@(negedge i_mclk);
		o_idle_req = (kind == 0);
		o_deep_req = (kind != 0);
		@(negedge i_mclk);
		o_idle_req = 1'b0;
		o_deep_req = 1'b0;
	endtask
	// One-cycle pulse on wake source n, prompt or late
	task automatic wake(input int n, input int dly);
		repeat (dly + 1) @(negedge i_mclk);
		o_wake[n] = 1'b1;
		@(negedge i_mclk);
		o_wake = 4'h0;
	endtask
	task automatic reset_pin(input logic level);
		@(negedge i_mclk);
		o_reset_pin_n = level;
	endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench: CPU partner drives the controller, a small model predicts it.
// Assumes the package and the defines header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_hs_use_crystal, i_ls_use_crystal;
	logic        i_idle_req, i_deep_req, i_deep_target, i_reset_pin_n;
	logic        i_irq, i_rtc_event, i_sensor_event, i_ext_wake;
	logic [29:0] i_gpio_in, i_gpio_out, i_shutdown_wake_en, o_gpio_pad, exp_pad;
	logic [5:0]  o_mode;
	logic [1:0]  o_reg_retention, o_reset_cause;
	logic        o_cpu_clk_en, o_mem_clk_en, o_periph_clk_en, o_always_on_domain_pwr;
	logic        o_sensor_ctrl_pwr, o_high_speed_crystal_osc_en, o_high_speed_rc_osc_en;
	logic        o_medium_speed_rc_osc_en, o_low_speed_crystal_osc_en, o_low_speed_rc_osc_en;
	logic        o_brownout_detector_en, o_watchdog_timer_run, o_sram_retain;
	logic        o_cpu_resume, o_sys_reset, o_io_latched;
	int          fail_count = 0, samples_checked = 0, cycles = 0, hits, k;
	pmc_cpu_partner cpu (.i_mclk(i_mclk), .o_idle_req(i_idle_req), .o_deep_req(i_deep_req),
		.o_deep_target(i_deep_target), .o_wake({i_ext_wake, i_sensor_event, i_rtc_event, i_irq}),
		.o_reset_pin_n(i_reset_pin_n));
	power_mode_controller dut (.*);
	// Clock and a hang limit well above the few hundred cycles the tests need
	always #5 i_mclk = ~i_mclk;
	always @(posedge i_mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic check(input string what, input logic [29:0] got, input logic [29:0] want);
		samples_checked++;
		if (got !== want)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, want, got);
		end
	endtask
	// Bench model of every per-mode enable, built from the mode table and the source selects
	task automatic compare_model(input logic [5:0] m);
		logic        run;
		logic        always_on_domain;
		logic        stb;
		logic [16:0] want;
		logic [16:0] got;
		run  = (m == 6'h01) || (m == 6'h02);
		always_on_domain  = (m != 6'h08) && (m != 6'h10);
		stb  = (m == 6'h04);
		want = {m == 6'h01, m == 6'h01, run, always_on_domain, always_on_domain, run && i_hs_use_crystal,
			run && !i_hs_use_crystal, always_on_domain, always_on_domain && i_ls_use_crystal, always_on_domain && !i_ls_use_crystal,
			always_on_domain, run, always_on_domain, (m == 6'h08) || (m == 6'h10) || (m == 6'h20),
			stb || (m == 6'h08) || (m == 6'h10), run ? 2'h2 : (stb ? 2'h1 : 2'h0)};
		got  = {o_cpu_clk_en, o_mem_clk_en, o_periph_clk_en, o_always_on_domain_pwr,
			o_sensor_ctrl_pwr, o_high_speed_crystal_osc_en, o_high_speed_rc_osc_en,
			o_medium_speed_rc_osc_en, o_low_speed_crystal_osc_en, o_low_speed_rc_osc_en,
			o_brownout_detector_en, o_watchdog_timer_run, o_sram_retain, o_sys_reset,
			o_io_latched, o_reg_retention};
		check("enables", 30'(got), 30'(want));
	endtask
	// Waits a bounded time for the predicted mode, then compares mode and enables
	task automatic reach(input logic [5:0] m, input int lim);
		for (int n = 0; n < lim && o_mode !== m; n++)
			@(negedge i_mclk);
		check("mode", o_mode, m);
		compare_model(m);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		void'($urandom(53522));
		{i_hs_use_crystal, i_ls_use_crystal, i_gpio_in, i_shutdown_wake_en} = '0;
		i_gpio_out = 30'($urandom);
		repeat (12) @(negedge i_mclk);
		check("mode in reset", o_mode, pmc_pkg::ST_WAKEUP);
		i_rst_n = 1'b1;
		reach(pmc_pkg::ST_ACTIVE, 16);
		check("cause", o_reset_cause, 2'h0);
		// The pad register follows the core outputs one cycle behind
		@(negedge i_mclk);
		exp_pad = i_gpio_out;
		check("pad", o_gpio_pad, exp_pad);
		cpu.request(0);
		reach(pmc_pkg::ST_IDLE, 2);
		check("cpu clock", o_cpu_clk_en, 1'b0);
		cpu.wake(1, 2);
		check("mode", o_mode, pmc_pkg::ST_IDLE);
		cpu.wake(0, $urandom_range(0, 5));
		reach(pmc_pkg::ST_ACTIVE, 2);
		$display("test idle done");
		for (int s = 1; s < 4; s++)
		begin
			{i_hs_use_crystal, i_ls_use_crystal} = 2'($urandom);
			cpu.request(1);
			reach(pmc_pkg::ST_STANDBY, 2);
			i_gpio_out = 30'($urandom);
			cpu.wake(0, 1);
			check("pad", o_gpio_pad, exp_pad);
			check("mode", o_mode, pmc_pkg::ST_STANDBY);
			cpu.wake(s, $urandom_range(0, 20));
			hits = 0;
			repeat (3)
			begin
				hits += int'(o_cpu_resume === 1'b1);
				@(negedge i_mclk);
			end
			check("mode", o_mode, pmc_pkg::ST_ACTIVE);
			compare_model(pmc_pkg::ST_ACTIVE);
			check("resume pulses", 30'(hits), 30'h1);
			exp_pad = i_gpio_out;
		end
		$display("test standby done");
		k = $urandom_range(0, 28);
		i_shutdown_wake_en = 30'h1 << k;
		check("pad", o_gpio_pad, exp_pad);
		cpu.request(2);
		reach(pmc_pkg::ST_SHUTDOWN, 2);
		i_gpio_out = ~i_gpio_out;
		i_gpio_in[k + 1] = 1'b1;
		repeat (8) @(negedge i_mclk);
		check("mode", o_mode, pmc_pkg::ST_SHUTDOWN);
		check("pad", o_gpio_pad, exp_pad);
		i_gpio_in[k] = 1'b1;
		reach(pmc_pkg::ST_WAKEUP, 6);
		check("system reset", o_sys_reset, 1'b1);
		reach(pmc_pkg::ST_ACTIVE, 14);
		@(negedge i_mclk);
		check("cause", o_reset_cause, 2'h2);
		$display("test shutdown done");
		for (int s = 0; s < 3; s++)
		begin
			cpu.request(s);
			cpu.reset_pin(1'b0);
			reach(pmc_pkg::ST_HELD, 6);
			repeat (4) @(negedge i_mclk);
			check("cpu clock", o_cpu_clk_en, 1'b0);
			cpu.reset_pin(1'b1);
			reach(pmc_pkg::ST_WAKEUP, 6);
			reach(pmc_pkg::ST_ACTIVE, 14);
			@(negedge i_mclk);
			check("cause", o_reset_cause, 2'h1);
		end
		$display("test reset pin done");
		tally_and_finish();
	end
endmodule
bind power_mode_controller pmc_checker chk (.*);
`default_nettype wire
